// *** inc/ufshed_pkg.sv ***
// package for the under-frequency load shed decision block
package ufshed_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned DELAY_TICK_NS = 1000000;
  localparam int unsigned MS_CYCLES_DEF = DELAY_TICK_NS / CLK_PERIOD_NS;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FREQ_THR = 8'h04;
  localparam logic [7:0] OFS_FREQ_THR_ALT = 8'h08;
  localparam logic [7:0] OFS_DELAY = 8'h0c;
  localparam logic [7:0] OFS_DELAY_ALT = 8'h10;
  localparam logic [7:0] OFS_MIN_CURR = 8'h14;
  localparam logic [7:0] OFS_MIN_POWER = 8'h18;
  localparam logic [7:0] OFS_ANGLE_TAN = 8'h1c;
  localparam logic [7:0] OFS_REL_VOLT = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // control register fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_METHOD_LSB = 1;
  localparam int unsigned CTRL_SIGN_NEG_BIT = 3;
  localparam int unsigned CTRL_EXT_ASSIGNED_BIT = 4;

  // status register fields
  localparam int unsigned STAT_UNDERFREQ_BIT = 0;
  localparam int unsigned STAT_RELEASED_BIT = 1;
  localparam int unsigned STAT_BLOCKED_BIT = 2;
  localparam int unsigned STAT_ALARM_BIT = 3;
  localparam int unsigned STAT_TRIP_BIT = 4;

  // reset values
  localparam logic [15:0] RST_FREQ_THR = 16'hbf68;
  localparam logic [15:0] RST_FREQ_THR_ALT = 16'hbe6e;
  localparam logic [15:0] RST_DELAY = 16'h0064;
  localparam logic [15:0] RST_DELAY_ALT = 16'h00c8;
  localparam logic [15:0] RST_MIN_CURR = 16'h000a;
  localparam logic [15:0] RST_MIN_POWER = 16'h0000;
  localparam logic [15:0] RST_ANGLE_TAN = 16'h0100;
  localparam logic [15:0] RST_REL_VOLT = 16'h0000;
  localparam int unsigned TAN_FRAC_BITS = 8;

  // index of each synchronised binary input
  localparam int unsigned BIN_DIR_BLOCK = 0;
  localparam int unsigned BIN_EXT_DIR = 1;
  localparam int unsigned BIN_ALT_FREQ = 2;
  localparam int unsigned BIN_ALT_DELAY = 3;
  localparam int unsigned BIN_COUNT = 4;

  typedef enum logic [1:0] {
    METHOD_POWER_ANGLE = 2'h0,
    METHOD_PURE_ACTIVE = 2'h1,
    METHOD_IGNORE_OR_EXT = 2'h2
  } ufshed_method_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_TIMING = 2'h1,
    ST_TRIP = 2'h3
  } ufshed_state_t;

  // measured quantities, all same-clock
  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] line_volt;
    logic [15:0] pos_seq_current;
    logic signed [15:0] pos_seq_active_power;
    logic signed [15:0] pos_seq_reactive_power;
  } ufshed_meas_t;

  typedef struct packed {
    logic enable;
    logic [1:0] direction_method_select;
    logic sign_negative;
    logic ext_assigned;
    logic [15:0] freq_thr;
    logic [15:0] freq_thr_alt;
    logic [15:0] shed_trip_delay;
    logic [15:0] shed_trip_delay_alt;
    logic [15:0] min_pos_seq_current;
    logic [15:0] min_power;
    logic [15:0] angle_tan;
    logic [15:0] release_volt;
  } ufshed_cfg_t;

endpackage

// *** hdl/ufshed_core.sv ***
// under-frequency load shed decision logic with register port
//
// Contract
// - direction uses positive-sequence active power, plus reactive power in angle mode
// - suppress input disables direction-based blocking
// - below minimum current, own-measurement direction supervision idle (external direction still blocks)
// - release only at or above release voltage
// - three direction methods selectable
// - angle mode blocks inside power-angle region
// - pure mode blocks above minimum power
// - ignore mode sheds on under-frequency and release voltage, without direction
// - external direction input replaces own measurement in ignore mode
// - under-frequency from settable, switchable threshold
// - delay timer starts when alarm raised
// - activation inputs select alternate threshold, delay
// - blocking regions use generator convention
// - sign setting negates active power
`timescale 1ns/1ps
module ufshed_core
  import ufshed_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // measurement front end
  input wire ufshed_meas_t meas_i,
  // assigned binary signals (asynchronous)
  input wire logic dir_eval_block_i,
  input wire logic external_direction_input_i,
  input wire logic alt_freq_select_i,
  input wire logic alt_delay_select_i,
  // result
  output logic shed_trip_o
);

  localparam int unsigned PRE_W = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES - 1);

  // refused at elaboration: the prescaler needs at least one cycle per tick
  if (MS_CYCLES < 1) begin : g_bad_ms_cycles
    $error("MS_CYCLES must be at least one");
  end

  // ---------------- binary input synchronisers ----------------
  logic [BIN_COUNT-1:0] bin_raw;
  logic [BIN_COUNT-1:0] sync1;
  logic [BIN_COUNT-1:0] sync2;
  logic [BIN_COUNT-1:0] sync3;
  logic [BIN_COUNT-1:0] bin_f;
  logic [BIN_COUNT-1:0] next_bin_f;

  assign bin_raw[BIN_DIR_BLOCK] = dir_eval_block_i;
  assign bin_raw[BIN_EXT_DIR] = external_direction_input_i;
  assign bin_raw[BIN_ALT_FREQ] = alt_freq_select_i;
  assign bin_raw[BIN_ALT_DELAY] = alt_delay_select_i;

  genvar gi;
  generate
    for (gi = 0; gi < BIN_COUNT; gi++) begin : g_sync
      // a level only counts once the last two stages agree
      always_comb begin
        next_bin_f[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : bin_f[gi];
      end
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          bin_f[gi] <= 1'b0;
        end else begin
          sync1[gi] <= bin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          bin_f[gi] <= next_bin_f[gi];
        end
      end
    end
  endgenerate

  // ---------------- registers ----------------
  ufshed_cfg_t cfg;
  ufshed_cfg_t next_cfg;
  logic [31:0] next_rdata;
  logic [31:0] status_word;

  always_comb begin
    next_cfg = cfg;
    if (wr_i) begin
      case (addr_i)
        OFS_CTRL: begin
          next_cfg.enable = wdata_i[CTRL_ENABLE_BIT];
          next_cfg.direction_method_select = wdata_i[CTRL_METHOD_LSB +: 2];
          next_cfg.sign_negative = wdata_i[CTRL_SIGN_NEG_BIT];
          next_cfg.ext_assigned = wdata_i[CTRL_EXT_ASSIGNED_BIT];
        end
        OFS_FREQ_THR: next_cfg.freq_thr = wdata_i[15:0];
        OFS_FREQ_THR_ALT: next_cfg.freq_thr_alt = wdata_i[15:0];
        OFS_DELAY: next_cfg.shed_trip_delay = wdata_i[15:0];
        OFS_DELAY_ALT: next_cfg.shed_trip_delay_alt = wdata_i[15:0];
        OFS_MIN_CURR: next_cfg.min_pos_seq_current = wdata_i[15:0];
        OFS_MIN_POWER: next_cfg.min_power = wdata_i[15:0];
        OFS_ANGLE_TAN: next_cfg.angle_tan = wdata_i[15:0];
        OFS_REL_VOLT: next_cfg.release_volt = wdata_i[15:0];
        default: next_cfg = cfg;
      endcase
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        OFS_CTRL: begin
          next_rdata[CTRL_ENABLE_BIT] = cfg.enable;
          next_rdata[CTRL_METHOD_LSB +: 2] = cfg.direction_method_select;
          next_rdata[CTRL_SIGN_NEG_BIT] = cfg.sign_negative;
          next_rdata[CTRL_EXT_ASSIGNED_BIT] = cfg.ext_assigned;
        end
        OFS_FREQ_THR: next_rdata[15:0] = cfg.freq_thr;
        OFS_FREQ_THR_ALT: next_rdata[15:0] = cfg.freq_thr_alt;
        OFS_DELAY: next_rdata[15:0] = cfg.shed_trip_delay;
        OFS_DELAY_ALT: next_rdata[15:0] = cfg.shed_trip_delay_alt;
        OFS_MIN_CURR: next_rdata[15:0] = cfg.min_pos_seq_current;
        OFS_MIN_POWER: next_rdata[15:0] = cfg.min_power;
        OFS_ANGLE_TAN: next_rdata[15:0] = cfg.angle_tan;
        OFS_REL_VOLT: next_rdata[15:0] = cfg.release_volt;
        OFS_STATUS: next_rdata = status_word;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cfg.enable <= 1'b0;
      cfg.direction_method_select <= METHOD_POWER_ANGLE;
      cfg.sign_negative <= 1'b0;
      cfg.ext_assigned <= 1'b0;
      cfg.freq_thr <= RST_FREQ_THR;
      cfg.freq_thr_alt <= RST_FREQ_THR_ALT;
      cfg.shed_trip_delay <= RST_DELAY;
      cfg.shed_trip_delay_alt <= RST_DELAY_ALT;
      cfg.min_pos_seq_current <= RST_MIN_CURR;
      cfg.min_power <= RST_MIN_POWER;
      cfg.angle_tan <= RST_ANGLE_TAN;
      cfg.release_volt <= RST_REL_VOLT;
      rdata_o <= 32'h0000_0000;
    end else begin
      cfg <= next_cfg;
      rdata_o <= next_rdata;
    end
  end

  // ---------------- decision path ----------------
  logic signed [16:0] p_used;
  logic [15:0] p_mag;
  logic [15:0] q_mag;
  logic current_ok;
  logic dir_eval;
  logic in_angle_region;
  logic blocked;
  logic released;
  logic underfreq;
  logic alarm;
  logic [15:0] thr_sel;
  logic [15:0] delay_sel;

  always_comb begin
    // widened so negating the most negative reading cannot wrap
    p_used = cfg.sign_negative ? -17'(meas_i.pos_seq_active_power)
                               : 17'(meas_i.pos_seq_active_power);
    p_mag = (p_used > 17'sd0) ? p_used[15:0] : 16'h0000;
    q_mag = meas_i.pos_seq_reactive_power[15] ? 16'(-17'(meas_i.pos_seq_reactive_power))
                                              : meas_i.pos_seq_reactive_power;
    current_ok = meas_i.pos_seq_current >= cfg.min_pos_seq_current;
    dir_eval = current_ok && !bin_f[BIN_DIR_BLOCK];
    // feeding (positive) power within +-angle around the P axis
    in_angle_region = (p_used > 17'sd0) &&
      (32'(p_mag) * 32'(cfg.angle_tan) >= (32'(q_mag) << TAN_FRAC_BITS));
    case (cfg.direction_method_select)
      METHOD_POWER_ANGLE: blocked = dir_eval && in_angle_region;
      METHOD_PURE_ACTIVE: blocked = dir_eval && (p_used > $signed({1'b0, cfg.min_power}));
      METHOD_IGNORE_OR_EXT: begin
        // external direction has no current to supervise
        blocked = cfg.ext_assigned && !bin_f[BIN_DIR_BLOCK] && bin_f[BIN_EXT_DIR];
      end
      default: blocked = 1'b0;
    endcase
    thr_sel = bin_f[BIN_ALT_FREQ] ? cfg.freq_thr_alt : cfg.freq_thr;
    delay_sel = bin_f[BIN_ALT_DELAY] ? cfg.shed_trip_delay_alt : cfg.shed_trip_delay;
    underfreq = meas_i.freq < thr_sel;
    released = meas_i.line_volt >= cfg.release_volt;
    alarm = cfg.enable && released && underfreq && !blocked;
  end

  // ---------------- trip delay timer ----------------
  ufshed_state_t state;
  ufshed_state_t next_state;
  logic [PRE_W-1:0] pre_cnt;
  logic [PRE_W-1:0] next_pre_cnt;
  logic [15:0] ms_cnt;
  logic [15:0] next_ms_cnt;
  logic next_trip;

  always_comb begin
    next_state = state;
    next_pre_cnt = pre_cnt;
    next_ms_cnt = ms_cnt;
    case (state)
      ST_IDLE: begin
        next_pre_cnt = '0;
        next_ms_cnt = 16'h0000;
        if (alarm) begin
          next_state = ST_TIMING;
        end
      end
      ST_TIMING: begin
        if (!alarm) begin
          next_state = ST_IDLE;
        end else if (ms_cnt >= delay_sel) begin
          next_state = ST_TRIP;
        end else if (pre_cnt == PRE_LAST) begin
          next_pre_cnt = '0;
          next_ms_cnt = ms_cnt + 16'h0001;
        end else begin
          next_pre_cnt = pre_cnt + PRE_W'(1);
        end
      end
      ST_TRIP: begin
        if (!alarm) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_trip = (next_state == ST_TRIP);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      pre_cnt <= '0;
      ms_cnt <= 16'h0000;
      shed_trip_o <= 1'b0;
    end else begin
      state <= next_state;
      pre_cnt <= next_pre_cnt;
      ms_cnt <= next_ms_cnt;
      shed_trip_o <= next_trip;
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_UNDERFREQ_BIT] = underfreq;
    status_word[STAT_RELEASED_BIT] = released;
    status_word[STAT_BLOCKED_BIT] = blocked;
    status_word[STAT_ALARM_BIT] = alarm;
    status_word[STAT_TRIP_BIT] = shed_trip_o;
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  chk_trip_needs_alarm: assert property ($rose(shed_trip_o) |-> $past(alarm))
    else $error("trip rose without alarm");
  chk_timer_cleared: assert property (!alarm && state != ST_IDLE |=>
    state == ST_IDLE ##1 ms_cnt == 16'h0000)
    else $error("timer not cleared after alarm drop");
  chk_timer_start: assert property (state == ST_IDLE && alarm |=> state == ST_TIMING)
    else $error("timer did not start on alarm");
  chk_release_volt: assert property (meas_i.line_volt < cfg.release_volt |-> !alarm)
    else $error("alarm below release voltage");
  chk_underfreq_thr: assert property (alarm |-> meas_i.freq < thr_sel)
    else $error("alarm without under-frequency");
  chk_alt_thr: assert property (bin_f[BIN_ALT_FREQ] && cfg.enable &&
    released && !blocked |-> alarm == (meas_i.freq < cfg.freq_thr_alt))
    else $error("alternate threshold not selected");
  chk_pure_block: assert property (
    cfg.direction_method_select == METHOD_PURE_ACTIVE && current_ok &&
    !bin_f[BIN_DIR_BLOCK] && p_used > $signed({1'b0, cfg.min_power}) |-> !alarm)
    else $error("pure mode did not block");
  chk_low_current: assert property (
    cfg.direction_method_select != METHOD_IGNORE_OR_EXT && !current_ok |-> !blocked)
    else $error("blocked below minimum current");
  chk_dir_suppress: assert property (bin_f[BIN_DIR_BLOCK] |-> !blocked)
    else $error("blocked while direction suppressed");
  chk_ignore_mode: assert property (
    cfg.direction_method_select == METHOD_IGNORE_OR_EXT && !cfg.ext_assigned |-> !blocked)
    else $error("ignore mode blocked");
  chk_ext_dir: assert property (
    cfg.direction_method_select == METHOD_IGNORE_OR_EXT && cfg.ext_assigned &&
    !bin_f[BIN_DIR_BLOCK] |-> blocked == bin_f[BIN_EXT_DIR])
    else $error("external direction not followed");
  chk_sign_negate: assert property (cfg.sign_negative |->
    p_used == -17'(meas_i.pos_seq_active_power))
    else $error("active power not negated");
  chk_angle_block: assert property (
    cfg.direction_method_select == METHOD_POWER_ANGLE && dir_eval && p_used > 17'sd0 &&
    meas_i.pos_seq_reactive_power == 16'sd0 |-> !alarm)
    else $error("angle mode did not block on pure feed");
  chk_read_one_cycle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data outside read slot");

  cov_trip: cover property (state == ST_TIMING ##1 shed_trip_o);
  cov_abort: cover property (state == ST_TIMING ##1 state == ST_IDLE);
  cov_block: cover property (underfreq && released && blocked);
  cov_alt_delay: cover property (bin_f[BIN_ALT_DELAY] && $rose(shed_trip_o));

endmodule

// *** sim/ufshed_front.sv ***
// measurement front end and relay binary signals feeding the shed block
`timescale 1ns/1ps
module ufshed_front
  import ufshed_pkg::*;
(
  // clock
  input wire logic clock_i,
  // measured quantities
  output ufshed_meas_t meas_o,
  // assigned binary signals
  output logic dir_eval_block_o,
  output logic ext_dir_o,
  output logic alt_freq_o,
  output logic alt_delay_o
);
  // idle front end reports full-scale frequency (16'hffff), so no alarm at start
  initial begin
    meas_o = {16'hffff, 64'h0};
    dir_eval_block_o = 1'b0;
    ext_dir_o = 1'b0;
    alt_freq_o = 1'b0;
    alt_delay_o = 1'b0;
  end

  task automatic apply(input logic [15:0] f, v, c, p, q);
    @(posedge clock_i);
    meas_o <= {f, v, c, p, q};
  endtask

  // binary pins pass a filter, so settle before measuring
  task automatic pins(input logic d, e, af, ad);
    @(posedge clock_i);
    dir_eval_block_o <= d;
    ext_dir_o <= e;
    alt_freq_o <= af;
    alt_delay_o <= ad;
    repeat (5) @(posedge clock_i);
  endtask
endmodule

// *** sim/tb_top.sv ***
// self-checking bench for the under-frequency load shed block
`timescale 1ns/1ps
module tb_top;
  import ufshed_pkg::*;
  localparam int unsigned MS = 2;
  localparam int LIMIT = 6000;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic shed_trip_o;
  ufshed_meas_t meas;
  logic dir_blk, ext_dir, alt_f, alt_d;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #50 clock_i = ~clock_i;

  ufshed_core #(.MS_CYCLES(MS)) ufshed_core_i (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .meas_i(meas),
    .dir_eval_block_i(dir_blk), .external_direction_input_i(ext_dir),
    .alt_freq_select_i(alt_f), .alt_delay_select_i(alt_d), .shed_trip_o(shed_trip_o));

  ufshed_front ufshed_front_i (
    .clock_i(clock_i), .meas_o(meas), .dir_eval_block_o(dir_blk),
    .ext_dir_o(ext_dir), .alt_freq_o(alt_f), .alt_delay_o(alt_d));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk(nm, e, rdata_o);
  endtask

  // n is the edge count to trip after the alarm starts, 0 for no trip
  task automatic run_case(input logic [15:0] f, v, c, p, q, input int n);
    int k;
    ufshed_front_i.apply(16'hffff, v, c, p, q);
    repeat (2) @(negedge clock_i);
    chk("trip idle", 32'h0, {31'h0, shed_trip_o});
    ufshed_front_i.apply(f, v, c, p, q);
    // first look falls inside the first alarm cycle, before any edge
    @(negedge clock_i);
    k = 0;
    while (k < 30 && shed_trip_o !== 1'b1) begin
      @(negedge clock_i);
      k++;
    end
    chk("trip edges", (n == 0) ? 32'd30 : 32'(n), 32'(k));
  endtask

  initial begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    rd_chk(OFS_CTRL, 32'h0, "ctrl");
    rd_chk(OFS_FREQ_THR, {16'h0, RST_FREQ_THR}, "freq thr");
    rd_chk(OFS_FREQ_THR_ALT, {16'h0, RST_FREQ_THR_ALT}, "freq thr alt");
    rd_chk(OFS_DELAY, {16'h0, RST_DELAY}, "delay");
    rd_chk(OFS_DELAY_ALT, {16'h0, RST_DELAY_ALT}, "delay alt");
    rd_chk(OFS_MIN_CURR, {16'h0, RST_MIN_CURR}, "min curr");
    rd_chk(OFS_MIN_POWER, {16'h0, RST_MIN_POWER}, "min power");
    rd_chk(OFS_ANGLE_TAN, {16'h0, RST_ANGLE_TAN}, "angle tan");
    rd_chk(OFS_REL_VOLT, {16'h0, RST_REL_VOLT}, "rel volt");
    rd_chk(8'h28, 32'h0, "unmapped");
    wr(OFS_FREQ_THR, 32'h1000);
    wr(OFS_FREQ_THR_ALT, 32'h0800);
    wr(OFS_DELAY, 32'h2);
    wr(OFS_DELAY_ALT, 32'h5);
    wr(OFS_MIN_CURR, 32'h10);
    wr(OFS_MIN_POWER, 32'h20);
    wr(OFS_REL_VOLT, 32'h100);
    wr(OFS_STATUS, 32'hffff);
    rd_chk(OFS_FREQ_THR, 32'h1000, "freq thr set");
    // method 2 without external direction: frequency and release voltage decide
    wr(OFS_CTRL, 32'h5);
    run_case(16'h0fff, 16'h100, 16'h10, 16'h7000, 16'h0, 2 * MS + 2);
    rd_chk(OFS_STATUS, 32'h1b, "status");
    run_case(16'h1000, 16'h100, 16'h10, 16'h0, 16'h0, 0);
    run_case(16'h0fff, 16'h0ff, 16'h10, 16'h0, 16'h0, 0);
    // alarm dropped before expiry must restart the delay from zero
    ufshed_front_i.apply(16'h0fff, 16'h100, 16'h10, 16'h0, 16'h0);
    repeat (4) @(negedge clock_i);
    chk("trip early", 32'h0, {31'h0, shed_trip_o});
    run_case(16'h0fff, 16'h100, 16'h10, 16'h0, 16'h0, 2 * MS + 2);
    ufshed_front_i.pins(1'b0, 1'b0, 1'b1, 1'b0);
    run_case(16'h0900, 16'h100, 16'h10, 16'h0, 16'h0, 0);
    run_case(16'h07ff, 16'h100, 16'h10, 16'h0, 16'h0, 2 * MS + 2);
    ufshed_front_i.pins(1'b0, 1'b0, 1'b0, 1'b1);
    run_case(16'h0fff, 16'h100, 16'h10, 16'h0, 16'h0, 5 * MS + 2);
    ufshed_front_i.pins(1'b0, 1'b0, 1'b0, 1'b0);
    // pure active power supervision
    wr(OFS_CTRL, 32'h3);
    run_case(16'h0fff, 16'h100, 16'h10, 16'h21, 16'h0, 0);
    run_case(16'h0fff, 16'h100, 16'h10, 16'h20, 16'h0, 2 * MS + 2);
    run_case(16'h0fff, 16'h100, 16'h0f, 16'h21, 16'h0, 2 * MS + 2);
    ufshed_front_i.pins(1'b1, 1'b0, 1'b0, 1'b0);
    run_case(16'h0fff, 16'h100, 16'h10, 16'h21, 16'h0, 2 * MS + 2);
    ufshed_front_i.pins(1'b0, 1'b0, 1'b0, 1'b0);
    // load convention: consumed power negative after sign reversal
    wr(OFS_CTRL, 32'hb);
    run_case(16'h0fff, 16'h100, 16'h10, 16'hffdf, 16'h0, 0);
    run_case(16'h0fff, 16'h100, 16'h10, 16'h0021, 16'h0, 2 * MS + 2);
    // power angle supervision, 45 degree region
    wr(OFS_CTRL, 32'h1);
    run_case(16'h0fff, 16'h100, 16'h10, 16'h64, 16'h32, 0);
    run_case(16'h0fff, 16'h100, 16'h10, 16'h64, 16'hc8, 2 * MS + 2);
    run_case(16'h0fff, 16'h100, 16'h10, 16'hff9c, 16'h0, 2 * MS + 2);
    // external direction assigned, then method 3 without it
    wr(OFS_CTRL, 32'h15);
    ufshed_front_i.pins(1'b0, 1'b1, 1'b0, 1'b0);
    run_case(16'h0fff, 16'h100, 16'h10, 16'h0, 16'h0, 0);
    ufshed_front_i.pins(1'b0, 1'b0, 1'b0, 1'b0);
    run_case(16'h0fff, 16'h100, 16'h10, 16'h7000, 16'h0, 2 * MS + 2);
    wr(OFS_CTRL, 32'h7);
    run_case(16'h0fff, 16'h100, 16'h10, 16'h7000, 16'h0, 2 * MS + 2);
    give_verdict();
  end
endmodule
